// >>> include/rifp_pkg.sv
package rifp_pkg;
    // register byte addresses
    localparam logic [7:0] RIFP_FLAG_IO_ADDR = 8'h00;
    localparam logic [7:0] RIFP_BUS_CTRL_ADDR = 8'h04;
    localparam logic [7:0] RIFP_CORE_CMD_ADDR = 8'h08;
    localparam logic [7:0] RIFP_STATUS_ADDR = 8'h0c;
    localparam logic [7:0] RIFP_INT_ADDR = 8'h10;
    // flag io control field positions
    localparam int RIFP_DIR0_BIT = 1;
    localparam int RIFP_OUT0_BIT = 2;
    localparam int RIFP_IN0_BIT = 3;
    localparam int RIFP_DIR1_BIT = 5;
    localparam int RIFP_OUT1_BIT = 6;
    localparam int RIFP_IN1_BIT = 7;
    // core command bits
    localparam int RIFP_CMD_STORE_BIT = 0;
    localparam int RIFP_CMD_CONFLICT_BIT = 1;
    localparam int RIFP_CMD_SIGNAL_BIT = 2;
    localparam int RIFP_CMD_LOAD_BIT = 3;
    localparam int RIFP_CMD_ACK_BIT = 4;
    localparam int RIFP_CMD_FETCH_BIT = 5;
    localparam int RIFP_CMD_MCMODE_BIT = 6;
    // reset values
    localparam logic [7:0] RIFP_FLAG_IO_RESET = 8'h00;
    localparam logic [3:0] RIFP_WAIT_RESET = 4'h7;
    localparam logic [3:0] RIFP_WAIT_NONE = 4'h0;
    // timing
    localparam int RIFP_CLOCK_MHZ = 20;
    localparam int RIFP_RESET_MIN_CYCLES = 10;
    localparam logic [3:0] RIFP_RESET_MIN = 4'ha;
    localparam logic [1:0] RIFP_VECTOR_FETCHES = 2'h2;
    localparam logic [1:0] RIFP_INT_SPACING = 2'h2;
    localparam logic [1:0] RIFP_RESP_OKAY = 2'h0;
    localparam logic [1:0] RIFP_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0]
    {
        RIFP_IDLE = 3'b000,
        RIFP_VEC_FETCH = 3'b001,
        RIFP_SIG_LOW = 3'b010,
        RIFP_SIG_WAIT = 3'b011,
        RIFP_LOAD_WAIT = 3'b100,
        RIFP_STORE_HOLD = 3'b101
    } rifp_state_t;
endpackage

// >>> include/rifp_irq_if.sv
`timescale 1ns/1ps
`default_nettype none
// one request line between top and its sampler
interface rifp_irq_if;
    logic line_n;
    logic taken;
    logic pending;
    modport top (output line_n, output taken, input pending);
    modport sampler (input line_n, input taken, output pending);
endinterface
`default_nettype wire

// >>> logic/rifp_irq_sampler.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------
// level interrupt sampler
// --------------------
module rifp_irq_sampler
    import rifp_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    rifp_irq_if.sampler irq
);
    typedef struct packed
    {
        logic pending;
        logic [1:0] gap;
    } rifp_irq_state_t;

    rifp_irq_state_t state;
    rifp_irq_state_t next_state;

    // level sampled once per cycle; re-arm after two cycles
    always_comb
    begin
        next_state = state;
        if (state.gap != 2'h0)
        begin
            next_state.gap = state.gap - 2'h1;
        end
        if (irq.taken)
        begin
            next_state.pending = 1'b0;
        end
        if (!irq.line_n && state.gap == 2'h0 && !state.pending)
        begin
            next_state.pending = 1'b1;
            next_state.gap = RIFP_INT_SPACING - 2'h1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign irq.pending = state.pending;
endmodule
`default_nettype wire

// >>> logic/rifp_pin_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - interlocked store drives out flag high at execute start
// - store address driven at execute, held back while conflict stalls
// - output value bits 2 and 6 drive the pins when outputs
// - direction bits 1 and 5 choose input or output
// - sampled pin levels appear in bits 3 and 7
// - reset taken at any cycle point; sequence may slip one cycle
// - flag, serial and timer pins float during reset
// - buses float, strobes held high during reset
// - reset loads bus control with seven wait states
// - reset vector fetched twice; seven waits or none by mode
// - bus hold request honoured even during reset
// - interrupt lines are level inputs sampled each cycle
// - core acts on interrupts only at fetch boundaries
// - same source accepted again every two cycles
// - ack strobe low at decode start, high at read start
// - ack strobe low exactly one cycle despite decode stretch
module rifp_pin_ctrl
    import rifp_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic flag0_in,
    output logic flag0_out,
    output logic flag0_oe,
    input wire logic flag1_in,
    output logic flag1_out,
    output logic flag1_oe,
    input wire logic [3:0] interrupt_request_lines_n,
    output logic interrupt_ack_strobe_n,
    output logic [3:0] interrupt_to_core,
    input wire logic fetch_boundary,
    input wire logic hold_request,
    output logic hold_ack,
    output logic bus_oe,
    output logic access_strobe_n,
    output logic read_write,
    output logic store_address_drive,
    output logic load_complete,
    output logic [3:0] wait_states,
    output logic periph_pins_oe
);
    // --------------------
    // state
    // --------------------
    typedef struct packed
    {
        logic [7:0] flag_io;
        logic [3:0] bus_wait;
        logic [3:0] reset_count;
        logic in_reset;
        rifp_state_t mode;
        logic [1:0] fetch_left;
        logic [3:0] wait_count;
        logic ack_low;
        logic ack_done;
        logic store_pending;
        logic addr_drive;
        logic load_done;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_access_strobe;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [3:0] int_seen;
    } rifp_core_t;

    rifp_core_t state;
    rifp_core_t next_state;
    logic [3:0] pending;
    logic [3:0] take;
    logic [31:0] cmd;
    logic cmd_write;

    // --------------------
    // interrupt samplers, one per line
    // --------------------
    genvar i;
    generate
        for (i = 0; i < 4; i++)
        begin : g_irq
            rifp_irq_if irq ();
            assign irq.line_n = interrupt_request_lines_n[i];
            assign irq.taken = take[i];
            assign pending[i] = irq.pending;
            rifp_irq_sampler u_samp
            (
                .clock(clock),
                .reset(reset),
                .irq(irq)
            );
        end
    endgenerate

    // released to the core only at a fetch boundary
    assign take = fetch_boundary ? pending : 4'h0;
    assign cmd_write = state.aw_held && state.w_held && !state.bvalid
        && state.aw_addr == RIFP_CORE_CMD_ADDR;
    assign cmd = cmd_write ? state.w_data : 32'h0;

    // --------------------
    // next state
    // --------------------
    always_comb
    begin
        next_state = state;
        next_state.ack_low = 1'b0;
        // count reset length for status
        if (state.in_reset && state.reset_count != RIFP_RESET_MIN)
        begin
            next_state.reset_count = state.reset_count + 4'h1;
        end
        // release: two vector fetches follow
        if (state.in_reset)
        begin
            next_state.in_reset = 1'b0;
            next_state.mode = RIFP_VEC_FETCH;
            next_state.fetch_left = RIFP_VECTOR_FETCHES;
            next_state.wait_count = state.bus_wait;
        end
        // sampled flag levels land in the input bits
        next_state.flag_io[RIFP_IN0_BIT] = flag0_oe ? flag0_out : flag0_in;
        next_state.flag_io[RIFP_IN1_BIT] = flag1_oe ? flag1_out : flag1_in;
        next_state.int_seen = state.int_seen | take;
        // ack strobe: exactly one cycle per request
        if (cmd[RIFP_CMD_ACK_BIT])
        begin
            next_state.ack_low = 1'b1;
        end
        next_state.addr_drive = 1'b0;
        next_state.load_done = 1'b0;
        case (state.mode)
            RIFP_IDLE:
            begin
                if (cmd[RIFP_CMD_STORE_BIT])
                begin
                    next_state.flag_io[RIFP_OUT0_BIT] = 1'b1;
                    if (cmd[RIFP_CMD_CONFLICT_BIT])
                    begin
                        next_state.mode = RIFP_STORE_HOLD;
                    end
                    else
                    begin
                        next_state.addr_drive = 1'b1;
                    end
                end
                else if (cmd[RIFP_CMD_SIGNAL_BIT])
                begin
                    next_state.flag_io[RIFP_OUT0_BIT] = 1'b0;
                    next_state.mode = RIFP_SIG_LOW;
                end
                else if (cmd[RIFP_CMD_LOAD_BIT])
                begin
                    next_state.flag_io[RIFP_OUT0_BIT] = 1'b0;
                    next_state.mode = RIFP_LOAD_WAIT;
                end
            end
            RIFP_STORE_HOLD:
            begin
                // address held back until the stall clears
                if (cmd_write && !state.w_data[RIFP_CMD_CONFLICT_BIT])
                begin
                    next_state.addr_drive = 1'b1;
                    next_state.mode = RIFP_IDLE;
                end
            end
            RIFP_SIG_LOW:
            begin
                next_state.mode = RIFP_SIG_WAIT;
            end
            RIFP_SIG_WAIT:
            begin
                if (!state.flag_io[RIFP_IN1_BIT])
                begin
                    next_state.flag_io[RIFP_OUT0_BIT] = 1'b1;
                    next_state.mode = RIFP_IDLE;
                end
            end
            RIFP_LOAD_WAIT:
            begin
                if (!state.flag_io[RIFP_IN1_BIT])
                begin
                    next_state.load_done = 1'b1;
                    next_state.mode = RIFP_IDLE;
                end
            end
            RIFP_VEC_FETCH:
            begin
                // microcomputer mode fetches without waits
                if (state.wait_count == 4'h0 || cmd[RIFP_CMD_MCMODE_BIT])
                begin
                    next_state.fetch_left = state.fetch_left - 2'h1;
                    next_state.wait_count = state.bus_wait;
                    if (state.fetch_left == 2'h1)
                    begin
                        next_state.mode = RIFP_IDLE;
                    end
                end
                else
                begin
                    next_state.wait_count = state.wait_count - 4'h1;
                end
            end
            default:
            begin
                next_state.mode = RIFP_IDLE;
            end
        endcase
        // --------------------
        // axi write channel
        // --------------------
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_state.w_held = 1'b1;
            next_state.w_data = s_axi_wdata;
            next_state.w_access_strobe = s_axi_wstrb;
        end
        if (state.aw_held && state.w_held && !state.bvalid)
        begin
            next_state.bvalid = 1'b1;
            next_state.bresp = RIFP_RESP_OKAY;
            next_state.aw_held = 1'b0;
            next_state.w_held = 1'b0;
            case (state.aw_addr)
                RIFP_FLAG_IO_ADDR:
                begin
                    if (state.w_access_strobe[0])
                    begin
                        // only direction and value bits are writable
                        next_state.flag_io[RIFP_DIR0_BIT] = state.w_data[RIFP_DIR0_BIT];
                        next_state.flag_io[RIFP_OUT0_BIT] = state.w_data[RIFP_OUT0_BIT];
                        next_state.flag_io[RIFP_DIR1_BIT] = state.w_data[RIFP_DIR1_BIT];
                        next_state.flag_io[RIFP_OUT1_BIT] = state.w_data[RIFP_OUT1_BIT];
                    end
                end
                RIFP_BUS_CTRL_ADDR:
                begin
                    if (state.w_access_strobe[0])
                    begin
                        next_state.bus_wait = state.w_data[3:0];
                    end
                end
                RIFP_CORE_CMD_ADDR:
                begin
                end
                RIFP_INT_ADDR:
                begin
                    // set wins over clear
                    next_state.int_seen = (state.int_seen & ~state.w_data[3:0]) | take;
                end
                default:
                begin
                    next_state.bresp = RIFP_RESP_SLVERR;
                end
            endcase
        end
        if (state.bvalid && s_axi_bready)
        begin
            next_state.bvalid = 1'b0;
        end
        // --------------------
        // axi read channel
        // --------------------
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_state.rvalid = 1'b1;
            next_state.rresp = RIFP_RESP_OKAY;
            case (s_axi_araddr[7:0])
                RIFP_FLAG_IO_ADDR: next_state.rdata = {24'h0, state.flag_io};
                RIFP_BUS_CTRL_ADDR: next_state.rdata = {28'h0, state.bus_wait};
                RIFP_CORE_CMD_ADDR: next_state.rdata = 32'h0;
                RIFP_STATUS_ADDR: next_state.rdata = {24'h0, state.reset_count,
                    1'b0, state.mode};
                RIFP_INT_ADDR: next_state.rdata = {24'h0, pending, state.int_seen};
                default:
                begin
                    next_state.rdata = 32'h0;
                    next_state.rresp = RIFP_RESP_SLVERR;
                end
            endcase
        end
        else if (state.rvalid && s_axi_rready)
        begin
            next_state.rvalid = 1'b0;
        end
    end

    // --------------------
    // registers
    // --------------------
    // reset is sampled each edge; a late assertion slips one cycle
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state <= '0;
            state.bus_wait <= RIFP_WAIT_RESET;
            state.flag_io <= RIFP_FLAG_IO_RESET;
            state.in_reset <= 1'b1;
            state.reset_count <= (state.reset_count == RIFP_RESET_MIN)
                ? RIFP_RESET_MIN : state.reset_count + 4'h1;
        end
        else
        begin
            state <= next_state;
        end
    end

    // --------------------
    // pins
    // --------------------
    // flag pins float during reset, follow direction bits otherwise
    assign flag0_oe = !reset && state.flag_io[RIFP_DIR0_BIT];
    assign flag1_oe = !reset && state.flag_io[RIFP_DIR1_BIT];
    assign flag0_out = state.flag_io[RIFP_OUT0_BIT];
    assign flag1_out = state.flag_io[RIFP_OUT1_BIT];
    assign periph_pins_oe = !reset;
    assign bus_oe = !reset && !hold_request;
    assign hold_ack = hold_request;
    assign access_strobe_n = 1'b1;
    assign read_write = 1'b1;
    assign interrupt_ack_strobe_n = reset || !state.ack_low;
    assign interrupt_to_core = take;
    assign store_address_drive = state.addr_drive;
    assign load_complete = state.load_done;
    // programmed bus wait count
    assign wait_states = state.bus_wait;
    assign s_axi_awready = !state.aw_held && !state.bvalid;
    assign s_axi_wready = !state.w_held && !state.bvalid;
    assign s_axi_bvalid = state.bvalid;
    assign s_axi_bresp = state.bresp;
    assign s_axi_arready = !state.rvalid;
    assign s_axi_rvalid = state.rvalid;
    assign s_axi_rdata = state.rdata;
    assign s_axi_rresp = state.rresp;
endmodule
`default_nettype wire

// >>> sim/rifp_pin_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module rifp_pin_ctrl_checker
    import rifp_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic flag0_oe,
    input wire logic flag1_oe,
    input wire logic flag0_out,
    input wire logic flag1_in,
    input wire logic [3:0] interrupt_to_core,
    input wire logic fetch_boundary,
    input wire logic interrupt_ack_strobe_n,
    input wire logic hold_request,
    input wire logic hold_ack,
    input wire logic bus_oe,
    input wire logic access_strobe_n,
    input wire logic read_write,
    input wire logic store_address_drive,
    input wire logic load_complete,
    input wire logic [3:0] wait_states,
    input wire logic periph_pins_oe
);
    default clocking dcb @(posedge clock);
    endclocking
    // --------------------
    // pins while held in reset
    // --------------------
    // reset itself is watched, so no disable here
    pins_float_a:
        assert property (reset |-> !flag0_oe && !flag1_oe && !periph_pins_oe)
        else $error("pins driven in reset");
    strobes_idle_a:
        assert property (reset |-> access_strobe_n && read_write
            && interrupt_ack_strobe_n && !bus_oe)
        else $error("strobes or bus active in reset");
    wait_init_a:
        assert property (reset |=> wait_states == RIFP_WAIT_RESET)
        else $error("wait count not seven after reset");
    hold_grant_a:
        assert property (hold_request |-> hold_ack && !bus_oe)
        else $error("hold request not honoured");
    // --------------------
    // running behaviour
    // --------------------
    sequence ack_drop_s;
        $fell(interrupt_ack_strobe_n);
    endsequence
    sequence ack_rise_s;
        ##1 interrupt_ack_strobe_n;
    endsequence
    periph_on_a:
        assert property (disable iff (reset) periph_pins_oe && bus_oe == !hold_request)
        else $error("pin enables wrong out of reset");
    ack_once_a:
        assert property (disable iff (reset) ack_drop_s |-> ack_rise_s)
        else $error("ack strobe not one cycle");
    irq_gate_a:
        assert property (disable iff (reset) (|interrupt_to_core) |-> fetch_boundary)
        else $error("interrupt off a fetch boundary");
    store_flag_a:
        assert property (disable iff (reset) store_address_drive |-> flag0_out
            ##1 !store_address_drive)
        else $error("store address without flag high");
    load_gate_a:
        assert property (disable iff (reset)
            load_complete |-> !$past(flag1_in) || !$past(flag1_in, 2))
        else $error("load done without flag sampled low");
endmodule
bind rifp_pin_ctrl rifp_pin_ctrl_checker u_rifp_pin_ctrl_checker (.clock, .reset, .flag0_oe,
    .flag1_oe, .flag0_out, .flag1_in, .interrupt_to_core, .fetch_boundary,
    .interrupt_ack_strobe_n, .hold_request, .hold_ack, .bus_oe, .access_strobe_n, .read_write,
    .store_address_drive, .load_complete, .wait_states, .periph_pins_oe);
`default_nettype wire

// >>> sim/rifp_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
module rifp_peer_model
#(
    parameter int GRANT_DELAY = 4
)
(
    input wire logic clock,
    input wire logic grant_req,
    input wire logic [3:0] fire,
    output logic flag_pull_low = 1'b0,
    output logic [3:0] irq_lines_n = 4'hf
);
    int wait_cnt = 0;
    // --------------------
    // far side sources
    // --------------------
    // one-cycle low pulse: one sample edge sees it, never two
    always_ff @(posedge clock)
        irq_lines_n <= ~fire;
    // interlock answered late; released line floats up
    always_ff @(posedge clock)
    begin
        wait_cnt <= grant_req ? wait_cnt + 1 : 0;
        flag_pull_low <= grant_req && (wait_cnt >= GRANT_DELAY);
    end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import rifp_pkg::*;
;
    localparam int GRANT_DELAY = 4;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [31:0] s_axi_rdata, rq;
    logic flag0_in, flag0_out, flag0_oe, flag1_in, flag1_out, flag1_oe;
    logic [3:0] interrupt_request_lines_n, interrupt_to_core, wait_states, fire = 4'h0;
    logic interrupt_ack_strobe_n, hold_ack, bus_oe, access_strobe_n, read_write;
    logic store_address_drive, load_complete, periph_pins_oe, flag_pull_low;
    logic fetch_boundary = 1'b1, hold_request = 1'b1, grant_req = 1'b0;
    int error_cnt = 0, checked = 0, store_cnt = 0, load_cnt = 0, ack_cnt = 0;
    int irq_cnt [4] = '{0, 0, 0, 0};

    rifp_pin_ctrl u_rifp_pin_ctrl (
        .clock, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .flag0_in, .flag0_out, .flag0_oe, .flag1_in, .flag1_out,
        .flag1_oe, .interrupt_request_lines_n, .interrupt_ack_strobe_n, .interrupt_to_core,
        .fetch_boundary, .hold_request, .hold_ack, .bus_oe, .access_strobe_n, .read_write,
        .store_address_drive, .load_complete, .wait_states, .periph_pins_oe
    );
    rifp_peer_model #(.GRANT_DELAY(GRANT_DELAY)) u_rifp_peer_model (
        .clock, .grant_req, .fire, .flag_pull_low, .irq_lines_n(interrupt_request_lines_n)
    );
    // --------------------
    // wires, clock, monitors
    // --------------------
    // released lines float up to their pull-ups
    assign flag0_in = flag0_oe ? flag0_out : 1'b1;
    assign flag1_in = flag1_oe ? flag1_out : !flag_pull_low;
    always #25 clock = ~clock;
    // counted mid-cycle, clear of edge races
    always @(negedge clock)
    begin
        if (!reset && store_address_drive === 1'b1) store_cnt++;
        if (!reset && load_complete === 1'b1) load_cnt++;
        if (!reset && interrupt_ack_strobe_n === 1'b0) ack_cnt++;
        for (int i = 0; i < 4; i++)
            if (!reset && interrupt_to_core[i] === 1'b1) irq_cnt[i]++;
    end
    // --------------------
    // shared tasks
    // --------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic pulse(input int i);
        fire <= 4'h1 << i;
        cyc(1);
        fire <= 4'h0;
    endtask
    // one transfer; each channel held until its own ready
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        rq = 32'hdead_beef;
        rr = 2'h3;
        if (wr)
        begin
            s_axi_awaddr <= {24'h0, a};
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end
        else
        begin
            s_axi_araddr <= {24'h0, a};
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        while (!done)
        begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
            begin
                rr = wr ? s_axi_bresp : s_axi_rresp;
                rq = s_axi_rdata;
                done = 1'b1;
                s_axi_bready <= 1'b0;
                s_axi_rready <= 1'b0;
            end
        end
        @(posedge clock); // transfers stay an edge apart
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axi(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        axi(1'b0, a, 32'h0);
    endtask
    task automatic print_verdict;
        $display("checked=%0d error_cnt=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // --------------------
    // scenarios
    // --------------------
    // hold asked in reset too; reset held ten cycles
    task automatic t_reset;
        reset <= 1'b1;
        hold_request <= 1'b1;
        cyc(10);
        chk({flag0_oe, flag1_oe, periph_pins_oe, bus_oe, hold_ack}, 32'h1);
        chk({access_strobe_n, read_write, interrupt_ack_strobe_n}, 32'h7);
        chk(wait_states, RIFP_WAIT_RESET);
        reset <= 1'b0;
        hold_request <= 1'b0;
        cyc(1);
        rd(RIFP_STATUS_ADDR);
        chk(rq[2:0], RIFP_VEC_FETCH);
        rd(RIFP_BUS_CTRL_ADDR);
        chk(rq, 32'h7);
        rd(RIFP_FLAG_IO_ADDR);
        chk(rq & 32'h66, 32'h0);
    endtask
    task automatic t_regs;
        wr(RIFP_BUS_CTRL_ADDR, 32'h3);
        cyc(1);
        chk(wait_states, 32'h3);
        rd(8'h20);
        chk({rr, rq[29:0]}, {RIFP_RESP_SLVERR, 30'h0});
        hold_request <= 1'b1;
        cyc(2);
        chk({hold_ack, bus_oe}, 32'h2);
        hold_request <= 1'b0;
    endtask
    task automatic t_flags;
        wr(RIFP_FLAG_IO_ADDR, 32'h26);
        cyc(1);
        chk({flag0_oe, flag0_out, flag1_oe, flag1_out}, 32'he);
        rd(RIFP_FLAG_IO_ADDR);
        chk(rq, 32'h2e);
        wr(RIFP_FLAG_IO_ADDR, 32'h40);
        grant_req <= 1'b1;
        cyc(GRANT_DELAY + 3);
        chk({flag0_oe, flag1_oe}, 32'h0);
        rd(RIFP_FLAG_IO_ADDR);
        chk(rq, 32'h48);
        grant_req <= 1'b0;
        cyc(2);
    endtask
    // stalled store first, then a plain one
    task automatic t_store;
        wr(RIFP_FLAG_IO_ADDR, 32'h02);
        store_cnt = 0;
        wr(RIFP_CORE_CMD_ADDR, 32'h3);
        cyc(4);
        chk(store_cnt, 0);
        wr(RIFP_CORE_CMD_ADDR, 32'h0);
        cyc(3);
        chk({flag0_out, 8'(store_cnt)}, 32'h101);
        wr(RIFP_CORE_CMD_ADDR, 32'h1);
        cyc(3);
        chk(store_cnt, 2);
    endtask
    task automatic t_interlock;
        wr(RIFP_FLAG_IO_ADDR, 32'h06);
        wr(RIFP_CORE_CMD_ADDR, 32'h04);
        cyc(4);
        chk(flag0_in, 32'h0);
        grant_req <= 1'b1;
        cyc(GRANT_DELAY + 4);
        chk(flag0_in, 32'h1);
        grant_req <= 1'b0;
        cyc(2);
        load_cnt = 0;
        wr(RIFP_CORE_CMD_ADDR, 32'h08);
        cyc(4);
        chk({flag0_in, 8'(load_cnt)}, 32'h0);
        grant_req <= 1'b1;
        cyc(GRANT_DELAY + 4);
        chk(load_cnt, 1);
        grant_req <= 1'b0;
        cyc(2);
    endtask
    // second pass adds the conflict bit, which stalls nothing without a store
    task automatic t_ack;
        for (int i = 0; i < 2; i++)
        begin
            ack_cnt = 0;
            wr(RIFP_CORE_CMD_ADDR, (i == 1) ? 32'h12 : 32'h10);
            wr(RIFP_CORE_CMD_ADDR, 32'h0);
            cyc(6);
            chk(ack_cnt, 1);
        end
    endtask
    task automatic t_irq;
        for (int i = 0; i < 4; i++)
        begin
            fetch_boundary <= 1'b0;
            pulse(i);
            cyc(4);
            chk(irq_cnt[i], 0);
            rd(RIFP_INT_ADDR);
            chk(rq, 32'h10 << i);
            fetch_boundary <= 1'b1;
            cyc(3);
            chk(irq_cnt[i], 1);
            pulse(i);
            cyc(1);
            pulse(i);
            cyc(4);
            chk(irq_cnt[i], 3);
            wr(RIFP_INT_ADDR, 32'h1 << i);
            rd(RIFP_INT_ADDR);
            chk(rq, 32'h0);
        end
    endtask
    // --------------------
    // run order and watchdog
    // --------------------
    // a mid-run reset last, to see the defaults return
    initial
    begin
        t_reset();
        t_regs();
        t_flags();
        t_store();
        t_interlock();
        t_ack();
        t_irq();
        t_reset();
        print_verdict();
    end
    // far beyond the few hundred cycles needed
    initial
    begin
        #2000000;
        error_cnt++;
        print_verdict();
    end
endmodule
`default_nettype wire
